// ### rtl/lps_map.svh
// Constants of the light and proximity sensor sequencer
// Contract
// RULE1: Separate interrupt enables for proximity and light
// RULE2: Four 16-bit thresholds, low and high each
// RULE3: Light event when visible result leaves window
// RULE4: Proximity event when result leaves window
// RULE5: Interrupt only after programmed persistence count
// RULE6: Sleep after reset until power-on bit set
// RULE7: Proximity accumulate then convert, then advance
// RULE8: Optional wait state, then light state
// RULE9: Long wait bit stretches wait twelvefold
// RULE10: Light accumulate, convert, latch, maybe interrupt
// RULE11: Host programs light integration of one step
// RULE12: Answer only slave address 0x39
// RULE13: Write: command byte first, then data
// RULE14: Combined: command, repeated start, read bytes
// RULE15: Plain read uses previously commanded address
// RULE16: First byte without top bit is data
// RULE17: Command is special function or register address
// RULE18: Register write uses command 0x80 plus address
// RULE19: Word read 0xA0 plus address, low first
// RULE20: Enable bits power, light, proximity, wait
// RULE21: Drive zero is 100 mA, 0x20 selects IR
// RULE22: Command bytes carry bit 7 set
// RULE23: Special 00101 clears prox, 00110 clears light
// RULE24: Interrupt stays until matching clear command
`ifndef LPS_MAP_SVH
`define LPS_MAP_SVH
`define LPS_SLAVE_ADDR 7'h39
`define LPS_CMD_BIT 7
`define LPS_TYPE_INC 2'h1
`define LPS_TYPE_SPECIAL 2'h3
`define LPS_SF_PROX_CLR 5'h05
`define LPS_SF_LIGHT_CLR 5'h06
`define LPS_R_ENABLE 5'h00
`define LPS_R_LIGHT_INTEGRATION_TIME 5'h01
`define LPS_R_PROX_INTEGRATION_TIME 5'h02
`define LPS_R_WAIT_TIME 5'h03
`define LPS_R_ALO 5'h04
`define LPS_R_AHI 5'h06
`define LPS_R_PLO 5'h08
`define LPS_R_PHI 5'h0A
`define LPS_R_PERS 5'h0C
`define LPS_R_CONFIG 5'h0D
`define LPS_R_EMITTER_PULSE_COUNT 5'h0E
`define LPS_R_CONTROL 5'h0F
`define LPS_R_REV 5'h11
`define LPS_R_ID 5'h12
`define LPS_R_STATUS 5'h13
`define LPS_R_CDATAL 5'h14
`define LPS_R_CDATAH 5'h15
`define LPS_R_IRDATAL 5'h16
`define LPS_R_IRDATAH 5'h17
`define LPS_R_PDATAL 5'h18
`define LPS_R_PDATAH 5'h19
`define LPS_RST_PROX_INTEGRATION_TIME 8'hFF
`define LPS_RST_WAIT_TIME 8'hFF
`define LPS_EN_PON 0
`define LPS_EN_AEN 1
`define LPS_EN_PEN 2
`define LPS_EN_WEN 3
`define LPS_EN_LIGHT_IRQ_ENABLE 4
`define LPS_EN_PROX_IRQ_ENABLE 5
`define LPS_CFG_LONG_WAIT_BIT 1
`define LPS_LONG_MULT 12'h00C
`define LPS_FULL_STEPS 9'h100
`define LPS_CLK_NS 40
`define LPS_STEP_NS 2720000
`define LPS_PULSE_NS 16000
`define LPS_PULSE_CYC (`LPS_PULSE_NS / `LPS_CLK_NS)
`define LPS_SCL_NS 10000
`define LPS_QTR_CYC ((`LPS_SCL_NS / 4 + `LPS_CLK_NS - 1) / `LPS_CLK_NS)
`define LPS_WB_CTRL 4'h0
`define LPS_WB_STATUS 4'h4
`define LPS_WB_RDATA 4'h8
`define LPS_OP_WRITE 2'h0
`define LPS_OP_READ 2'h1
`define LPS_OP_CMD 2'h2
`endif

// ### rtl/lps_pkg.sv
// Types shared by both ends of the sensor link
package lps_pkg;
  typedef enum logic [2:0] {
    LPS_I_IDLE, LPS_I_ADDR, LPS_I_WR, LPS_I_ACKW, LPS_I_ACK,
    LPS_I_RD, LPS_I_RACKW, LPS_I_RACK
  } lps_i2c_st_t;
  typedef enum logic [2:0] {
    LPS_S_SLEEP, LPS_S_PACC, LPS_S_PCONV, LPS_S_WAIT,
    LPS_S_AACC, LPS_S_ACONV
  } lps_seq_t;
  typedef enum logic [2:0] {
    LPS_K_START, LPS_K_RESTART, LPS_K_STOP, LPS_K_WBYTE,
    LPS_K_RACK, LPS_K_RNACK
  } lps_kind_t;
  typedef enum logic [1:0] {
    LPS_H_IDLE, LPS_H_COND, LPS_H_BIT
  } lps_host_st_t;
endpackage

// ### rtl/lps_if.sv
// Two-wire link between host and sensor, open drain
interface lps_if;
  logic scl_host_oe;
  logic scl_host_o;
  logic sda_host_oe;
  logic sda_host_o;
  logic sda_dev_oe;
  logic sda_dev_o;
  logic scl;
  logic sda;
  // Wired-and of the open-drain drivers
  assign scl = ~scl_host_oe;
  assign sda = ~(sda_host_oe | sda_dev_oe);
  modport dev (input scl, input sda, output sda_dev_oe,
    output sda_dev_o);
  modport host (input scl, input sda, output scl_host_oe,
    output scl_host_o, output sda_host_oe, output sda_host_o);
endinterface

// ### rtl/lps_sync.sv
// Two-flop synchroniser for the link pins
module lps_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] d_i,
  output logic [1:0] q_o
);
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
  } lps_sync_s_t;
  lps_sync_s_t q, d;
  // Second stage only is visible
  always_comb begin
    d = q;
    d.s1 = d_i;
    d.s2 = q.s1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.s1 <= 2'h3;
      q.s2 <= 2'h3;
    end else begin
      q <= d;
    end
  end
  assign q_o = q.s2;
endmodule

// ### rtl/lps_dev.sv
// Sensor end: two-wire slave, registers, sequencer, interrupt
`include "lps_map.svh"
module lps_dev
  import lps_pkg::*;
#(
  parameter int STEP_CYC = `LPS_STEP_NS / `LPS_CLK_NS,
  parameter logic [7:0] REV_VAL = 8'h01, // arbitrary value
  parameter logic [7:0] ID_VAL = 8'h5A // arbitrary value
) (
  input wire logic clk_i,
  input wire logic rst_i,
  lps_if.dev bus,
  input wire logic [15:0] light_sample_i,
  input wire logic [15:0] ir_sample_i,
  input wire logic [15:0] prox_sample_i,
  output logic int_n_o,
  output logic emitter_on_o,
  output logic [1:0] emitter_drive_select_o,
  output logic [1:0] prox_diode_select_o,
  output logic [1:0] prox_gain_select_o,
  output logic [1:0] light_gain_select_o
);
  typedef struct packed {
    lps_i2c_st_t st;
    lps_seq_t seq;
    logic [15:0][7:0] cfg;
    logic [15:0] cdat;
    logic [15:0] irdat;
    logic [15:0] pdat;
    logic avalid;
    logic pvalid;
    logic aint;
    logic pint;
    logic [3:0] apc;
    logic [3:0] ppc;
    logic [16:0] tick;
    logic [11:0] steps;
    logic [11:0] tgt;
    logic [7:0] sh;
    logic [3:0] bitn;
    logic [4:0] addr;
    logic [1:0] typ;
    logic first;
    logic rw;
    logic sda_oe;
    logic scl_p;
    logic sda_p;
    logic int_n;
    logic emit;
  } lps_dev_s_t;

  lps_dev_s_t q, d;
  logic [1:0] pin_s;
  logic [7:0] b;
  logic rise, fall, start, stop, a_out, p_out, done;
  logic [16:0] lim;

  lps_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({bus.scl, bus.sda}),
    .q_o(pin_s)
  );

  // Steps of a 2's complement time register
  function automatic logic [11:0] steps_of(input logic [7:0] t);
    steps_of = {3'h0, 9'(`LPS_FULL_STEPS - {1'b0, t})};
  endfunction

  // Result outside the threshold window
  function automatic logic outside(input logic [15:0] v,
    input logic [15:0] lo, input logic [15:0] hi);
    outside = (v < lo) || (v > hi);
  endfunction

  // Consecutive out-of-window count, saturating
  function automatic logic [3:0] pers_next(input logic [3:0] c,
    input logic o);
    pers_next = !o ? 4'h0 : ((c == 4'hF) ? c : 4'(c + 4'h1));
  endfunction

  // Register read decode
  function automatic logic [7:0] rd(input lps_dev_s_t s,
    input logic [4:0] a);
    if (!a[4]) begin
      rd = s.cfg[a[3:0]];
    end else begin
      case (a)
        `LPS_R_REV: rd = REV_VAL;
        `LPS_R_ID: rd = ID_VAL;
        `LPS_R_STATUS: rd = {2'h0, s.pint, s.aint, 2'h0, s.pvalid,
          s.avalid};
        `LPS_R_CDATAL: rd = s.cdat[7:0];
        `LPS_R_CDATAH: rd = s.cdat[15:8];
        `LPS_R_IRDATAL: rd = s.irdat[7:0];
        `LPS_R_IRDATAH: rd = s.irdat[15:8];
        `LPS_R_PDATAL: rd = s.pdat[7:0];
        `LPS_R_PDATAH: rd = s.pdat[15:8];
        default: rd = 8'h00;
      endcase
    end
  endfunction

  // Enter a measurement phase with a step target
  function automatic lps_dev_s_t enter(input lps_dev_s_t s,
    input lps_seq_t n, input logic [11:0] t);
    enter = s;
    enter.seq = n;
    enter.tick = '0;
    enter.steps = '0;
    enter.tgt = (t == 12'h000) ? 12'h001 : t;
  endfunction

  // Phase after proximity, or entry when proximity is off
  function automatic lps_dev_s_t after_prox(input lps_dev_s_t s);
    logic [7:0] en;
    en = s.cfg[`LPS_R_ENABLE];
    if (en[`LPS_EN_WEN]) begin // [RULE8]
      after_prox = enter(s, LPS_S_WAIT,
        s.cfg[`LPS_R_CONFIG][`LPS_CFG_LONG_WAIT_BIT] ?
        12'(steps_of(s.cfg[`LPS_R_WAIT_TIME]) * `LPS_LONG_MULT) :
        steps_of(s.cfg[`LPS_R_WAIT_TIME])); // [RULE9]
    end else if (en[`LPS_EN_AEN]) begin
      after_prox = enter(s, LPS_S_AACC,
        steps_of(s.cfg[`LPS_R_LIGHT_INTEGRATION_TIME]));
    end else begin
      after_prox = enter(s, LPS_S_SLEEP, 12'h001);
    end
  endfunction

  assign rise = pin_s[1] & ~q.scl_p;
  assign fall = ~pin_s[1] & q.scl_p;
  assign start = pin_s[1] & q.scl_p & q.sda_p & ~pin_s[0];
  assign stop = pin_s[1] & q.scl_p & ~q.sda_p & pin_s[0];
  assign b = {q.sh[6:0], pin_s[0]};
  // Four thresholds, low and high per channel [RULE2]
  assign a_out = outside(light_sample_i,
    {q.cfg[`LPS_R_ALO + 5'h01], q.cfg[`LPS_R_ALO]},
    {q.cfg[`LPS_R_AHI + 5'h01], q.cfg[`LPS_R_AHI]}); // [RULE3]
  assign p_out = outside(prox_sample_i,
    {q.cfg[`LPS_R_PLO + 5'h01], q.cfg[`LPS_R_PLO]},
    {q.cfg[`LPS_R_PHI + 5'h01], q.cfg[`LPS_R_PHI]}); // [RULE4]
  assign lim = (q.seq == LPS_S_PACC) ? 17'(`LPS_PULSE_CYC - 1) :
    17'(STEP_CYC - 1);
  assign done = (q.tick == lim) && (q.steps == 12'(q.tgt - 12'h001));

  always_comb begin
    d = q;
    d.scl_p = pin_s[1];
    d.sda_p = pin_s[0];
    // Two-wire slave byte engine
    if (stop) begin
      d.st = LPS_I_IDLE;
      d.sda_oe = 1'b0;
    end else if (start) begin
      d.st = LPS_I_ADDR;
      d.bitn = 4'h0;
      d.sda_oe = 1'b0;
      d.first = 1'b1;
    end else begin
      case (q.st)
        LPS_I_ADDR, LPS_I_WR: begin
          if (rise) begin
            d.sh = b;
            d.bitn = 4'(q.bitn + 4'h1);
            if (q.bitn == 4'h7) begin
              d.st = LPS_I_ACKW;
              if (q.st == LPS_I_ADDR) begin
                d.rw = b[0];
                if (b[7:1] != `LPS_SLAVE_ADDR) begin // [RULE12]
                  d.st = LPS_I_IDLE;
                end
              end else if (q.first && b[`LPS_CMD_BIT]) begin // [RULE22]
                d.first = 1'b0; // Command byte first [RULE13]
                d.typ = b[6:5];
                if (b[6:5] == `LPS_TYPE_SPECIAL) begin // [RULE17]
                  if (b[4:0] == `LPS_SF_PROX_CLR) d.pint = 1'b0;
                  if (b[4:0] == `LPS_SF_LIGHT_CLR) d.aint = 1'b0;
                end else begin
                  d.addr = b[4:0]; // Register address [RULE17] [RULE18]
                end
              end else begin
                d.first = 1'b0; // Data to stored address [RULE16]
                if (!q.addr[4]) d.cfg[q.addr[3:0]] = b;
                if (q.typ == `LPS_TYPE_INC) d.addr = 5'(q.addr + 5'h01);
              end
            end
          end
        end
        LPS_I_ACKW: begin
          if (fall) begin
            d.sda_oe = 1'b1;
            d.st = LPS_I_ACK;
          end
        end
        LPS_I_ACK: begin
          if (fall) begin
            d.bitn = 4'h0;
            d.sda_oe = 1'b0;
            d.st = LPS_I_WR;
            if (q.rw) begin // Read from current address [RULE14] [RULE15]
              d.sh = rd(q, q.addr);
              d.sda_oe = ~d.sh[7];
              d.st = LPS_I_RD;
              if (q.typ == `LPS_TYPE_INC) begin // Low then high [RULE19]
                d.addr = 5'(q.addr + 5'h01);
              end
            end
          end
        end
        LPS_I_RD: begin
          if (rise) begin
            d.bitn = 4'(q.bitn + 4'h1);
            if (q.bitn == 4'h7) d.st = LPS_I_RACKW;
          end else if (fall) begin
            d.sh = {q.sh[6:0], 1'b0};
            d.sda_oe = ~q.sh[6];
          end
        end
        LPS_I_RACKW: begin
          if (fall) begin
            d.sda_oe = 1'b0;
            d.st = LPS_I_RACK;
          end
        end
        LPS_I_RACK: begin
          if (rise) d.st = pin_s[0] ? LPS_I_IDLE : LPS_I_ACK;
        end
        default: d.st = LPS_I_IDLE;
      endcase
    end
    // Measurement sequencer
    if (q.seq != LPS_S_SLEEP) begin
      d.tick = (q.tick == lim) ? 17'h0 : 17'(q.tick + 17'h1);
      if (q.tick == lim) d.steps = 12'(q.steps + 12'h001);
    end
    if (!q.cfg[`LPS_R_ENABLE][`LPS_EN_PON]) begin // [RULE20]
      d = enter(d, LPS_S_SLEEP, 12'h001); // [RULE6]
    end else begin
      case (q.seq)
        LPS_S_SLEEP: begin
          if (q.cfg[`LPS_R_ENABLE][`LPS_EN_PEN]) begin // [RULE7]
            d = enter(d, LPS_S_PACC, {4'h0, q.cfg[`LPS_R_EMITTER_PULSE_COUNT]});
          end else begin
            d = after_prox(d);
          end
        end
        LPS_S_PACC: begin
          if (done) begin
            d = enter(d, LPS_S_PCONV, steps_of(q.cfg[`LPS_R_PROX_INTEGRATION_TIME]));
          end
        end
        LPS_S_PCONV: begin
          if (done) begin // Latch and advance at once [RULE7]
            d.pdat = prox_sample_i;
            d.pvalid = 1'b1;
            d.ppc = pers_next(q.ppc, p_out);
            if (p_out && q.ppc >= q.cfg[`LPS_R_PERS][7:4] &&
                q.cfg[`LPS_R_ENABLE][`LPS_EN_PROX_IRQ_ENABLE]) begin // [RULE1] [RULE5]
              d.pint = 1'b1; // Set wins over clear [RULE24]
            end
            d = after_prox(d);
          end
        end
        LPS_S_WAIT: begin
          if (done) begin // [RULE8]
            d = q.cfg[`LPS_R_ENABLE][`LPS_EN_AEN] ?
              enter(d, LPS_S_AACC, steps_of(q.cfg[`LPS_R_LIGHT_INTEGRATION_TIME])) :
              enter(d, LPS_S_SLEEP, 12'h001);
          end
        end
        LPS_S_AACC: begin
          if (done) d = enter(d, LPS_S_ACONV, 12'h001);
        end
        LPS_S_ACONV: begin // First cycle, without waiting for done: latch results [RULE10]
          d.cdat = light_sample_i;
          d.irdat = ir_sample_i;
          d.avalid = 1'b1;
          d.apc = pers_next(q.apc, a_out);
          if (a_out && q.apc >= q.cfg[`LPS_R_PERS][3:0] &&
              q.cfg[`LPS_R_ENABLE][`LPS_EN_LIGHT_IRQ_ENABLE]) begin // [RULE1] [RULE5]
            d.aint = 1'b1; // Held until cleared [RULE24]
          end
          d = enter(d, LPS_S_SLEEP, 12'h001);
        end
        default: d = enter(d, LPS_S_SLEEP, 12'h001);
      endcase
    end
    // Open-drain interrupt pin, active low
    d.int_n = ~((d.aint & d.cfg[`LPS_R_ENABLE][`LPS_EN_LIGHT_IRQ_ENABLE]) |
      (d.pint & d.cfg[`LPS_R_ENABLE][`LPS_EN_PROX_IRQ_ENABLE])); // [RULE1]
    d.emit = (d.seq == LPS_S_PACC) &&
      (d.tick < 17'(`LPS_PULSE_CYC / 2));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.cfg[`LPS_R_PROX_INTEGRATION_TIME] <= `LPS_RST_PROX_INTEGRATION_TIME;
      q.cfg[`LPS_R_WAIT_TIME] <= `LPS_RST_WAIT_TIME;
      q.tgt <= 12'h001;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
      q.int_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign bus.sda_dev_oe = q.sda_oe;
  assign bus.sda_dev_o = 1'b0;
  assign int_n_o = q.int_n;
  assign emitter_on_o = q.emit;
  // Drive field zero means 100 mA, diode 0x20 the IR diode [RULE21]
  assign emitter_drive_select_o = q.cfg[`LPS_R_CONTROL][7:6];
  assign prox_diode_select_o = q.cfg[`LPS_R_CONTROL][5:4];
  assign prox_gain_select_o = q.cfg[`LPS_R_CONTROL][3:2];
  assign light_gain_select_o = q.cfg[`LPS_R_CONTROL][1:0];
endmodule

// ### rtl/lps_host.sv
// Host end: Wishbone command registers and two-wire master
`include "lps_map.svh"
module lps_host
  import lps_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  lps_if.host bus,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  typedef struct packed {
    lps_host_st_t st;
    lps_kind_t kd;
    logic [1:0] op;
    logic [7:0] cmd;
    logic [7:0] data;
    logic [2:0] slot;
    logic [1:0] qt;
    logic [6:0] div;
    logic [8:0] tx;
    logic [8:0] rx;
    logic [3:0] bitn;
    logic [15:0] word;
    logic busy;
    logic nack;
    logic scl_oe;
    logic sda_oe;
    logic ack;
    logic [31:0] rdat;
  } lps_host_s_t;

  lps_host_s_t q, d;
  logic [1:0] pin_s;
  logic qtick;

  lps_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({bus.scl, bus.sda}),
    .q_o(pin_s)
  );

  // Set up slot n of the operation's sequence
  function automatic lps_host_s_t load(input lps_host_s_t s,
    input logic [2:0] n);
    load = s;
    load.slot = n;
    load.st = LPS_H_COND;
    load.qt = 2'h0;
    load.bitn = 4'h0;
    case (n)
      3'h0: load.kd = LPS_K_START;
      3'h1: load.kd = LPS_K_WBYTE;
      3'h2: load.kd = LPS_K_WBYTE;
      3'h3: load.kd = (s.op == `LPS_OP_WRITE) ? LPS_K_WBYTE :
        (s.op == `LPS_OP_READ) ? LPS_K_RESTART : LPS_K_STOP;
      3'h4: load.kd = (s.op == `LPS_OP_READ) ? LPS_K_WBYTE : LPS_K_STOP;
      3'h5: load.kd = LPS_K_RACK;
      3'h6: load.kd = LPS_K_RNACK;
      default: load.kd = LPS_K_STOP;
    endcase
    case (n)
      3'h1: load.tx = {`LPS_SLAVE_ADDR, 1'b0, 1'b1};
      3'h2: load.tx = {s.cmd, 1'b1}; // Command byte first [RULE13]
      3'h4: load.tx = {`LPS_SLAVE_ADDR, 1'b1, 1'b1}; // [RULE14]
      3'h5: load.tx = 9'h1FE;
      3'h6: load.tx = 9'h1FF;
      default: load.tx = {s.data, 1'b1};
    endcase
    if (load.kd inside {LPS_K_WBYTE, LPS_K_RACK, LPS_K_RNACK}) begin
      load.st = LPS_H_BIT;
    end
  endfunction

  assign qtick = (q.div == 7'(`LPS_QTR_CYC - 1));

  always_comb begin
    d = q;
    d.ack = 1'b0;
    // Wishbone slave, one wait state
    if (wb_cyc_i && wb_stb_i && !q.ack) begin
      d.ack = 1'b1;
      case (wb_adr_i)
        `LPS_WB_STATUS: d.rdat = {30'h0, q.nack, q.busy};
        `LPS_WB_RDATA: d.rdat = {16'h0, q.word};
        default: d.rdat = 32'h0;
      endcase
      if (wb_we_i && wb_adr_i == `LPS_WB_CTRL && wb_sel_i[0] && !q.busy) begin
        d.cmd = wb_dat_i[7:0];
        d.data = wb_dat_i[15:8];
        d.op = wb_dat_i[17:16];
        d.busy = 1'b1;
        d.nack = 1'b0;
        d.div = 7'h0;
        d = load(d, 3'h0);
      end
    end
    // Quarter-bit pacing of the serial clock
    if (q.st != LPS_H_IDLE) begin
      d.div = qtick ? 7'h0 : 7'(q.div + 7'h01);
    end
    if (qtick) begin
      d.qt = 2'(q.qt + 2'h1);
      case (q.st)
        LPS_H_COND: begin
          case (q.kd)
            LPS_K_START: begin
              if (q.qt == 2'h0) d.sda_oe = 1'b1;
              if (q.qt == 2'h1) begin
                d.scl_oe = 1'b1;
                d = load(d, 3'(q.slot + 3'h1));
              end
            end
            LPS_K_RESTART: begin
              if (q.qt == 2'h0) d.sda_oe = 1'b0;
              if (q.qt == 2'h1) d.scl_oe = 1'b0;
              if (q.qt == 2'h2) d.sda_oe = 1'b1;
              if (q.qt == 2'h3) begin
                d.scl_oe = 1'b1;
                d = load(d, 3'(q.slot + 3'h1));
              end
            end
            default: begin
              if (q.qt == 2'h0) d.sda_oe = 1'b1;
              if (q.qt == 2'h1) d.scl_oe = 1'b0;
              if (q.qt == 2'h2) begin
                d.sda_oe = 1'b0;
                d.busy = 1'b0;
                d.st = LPS_H_IDLE;
              end
            end
          endcase
        end
        LPS_H_BIT: begin
          if (q.qt == 2'h0) d.sda_oe = ~q.tx[8];
          if (q.qt == 2'h1) d.scl_oe = 1'b0;
          if (q.qt == 2'h2) d.rx = {q.rx[7:0], pin_s[0]};
          if (q.qt == 2'h3) begin
            d.scl_oe = 1'b1;
            d.tx = {q.tx[7:0], 1'b1};
            d.bitn = 4'(q.bitn + 4'h1);
            if (q.bitn == 4'h8) begin
              d.sda_oe = 1'b0;
              // Word arrives low byte first [RULE19]
              if (q.kd == LPS_K_RACK) d.word[7:0] = q.rx[8:1];
              if (q.kd == LPS_K_RNACK) d.word[15:8] = q.rx[8:1];
              if (q.kd == LPS_K_WBYTE && q.rx[0]) begin
                d.nack = 1'b1;
                d = load(d, 3'h7);
              end else begin
                d = load(d, 3'(q.slot + 3'h1));
              end
            end
          end
        end
        default: d.st = LPS_H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.scl_host_oe = q.scl_oe;
  assign bus.sda_host_oe = q.sda_oe;
  assign bus.scl_host_o = 1'b0;
  assign bus.sda_host_o = 1'b0;
  assign wb_dat_o = q.rdat;
  assign wb_ack_o = q.ack;
endmodule

// ### sim/lps_link_properties.sv
// Checker for the two-wire link between host and sensor
module lps_link_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_host_oe,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe
);
  logic scl_q, sda_q, first_q, rise, start;
  logic [7:0] sh_q;
  logic [3:0] cnt_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Edge and start detection on the sampled wires
  assign rise = scl && !scl_q;
  assign start = scl && scl_q && sda_q && !sda;
  // Bit counter, restarted at every start condition
  always_ff @(posedge clk_i) begin
    scl_q <= scl;
    sda_q <= sda;
    if (rst_i) begin
      first_q <= 1'b0;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
    end else if (start) begin
      first_q <= 1'b1;
      cnt_q <= 4'h0;
    end else if (rise) begin
      sh_q <= {sh_q[6:0], sda};
      cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
      if (cnt_q == 4'h8) begin
        first_q <= 1'b0;
      end
    end
  end
  chk_idle_after_rst: assert property (
    $fell(rst_i) |-> !scl_host_oe && !sda_host_oe && !sda_dev_oe)
    else $error("lines not released after reset");
  chk_addr_ack_match: assert property (
    rise && first_q && cnt_q == 4'h8 |-> sda_dev_oe == (sh_q[7:1] == 7'h39))
    else $error("address acknowledge wrong");
  chk_dev_change_low: assert property (
    $changed(sda_dev_oe) |-> !scl)
    else $error("device moved data while clock high");
  chk_dev_hold_high: assert property (
    $rose(scl) && sda_dev_oe |-> sda_dev_oe [*8])
    else $error("device released data during clock high");
  chk_no_dev_start: assert property (
    start |-> !sda_dev_oe)
    else $error("device drives data at a start");
  chk_dev_drive_late: assert property (
    $rose(sda_dev_oe) |-> !scl && !$past(scl))
    else $error("device drove data too early");
  chk_scl_high_span: assert property (
    $rose(scl) |=> scl [*8])
    else $error("clock high phase too short");
  chk_scl_low_span: assert property (
    $fell(scl) |=> !scl [*8])
    else $error("clock low phase too short");
  cover property (rise && first_q && cnt_q == 4'h8 && sda_dev_oe);
  cover property (start);
  cover property (scl && scl_q && !sda_q && sda);
endmodule

// ### sim/tb_light_prox_sensor_sequencer.sv
// Bench: host and sensor ends joined over the two-wire link
module tb_light_prox_sensor_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 100000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, wb_ack_o, int_n_o, emit;
  wire [7:0] sel;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, wb_dat_o;
  logic [15:0] light_s = 16'h0, ir_s = 16'h0, prox_s = 16'h0, word;
  int miscompares = 0, check_count = 0, cycles = 0, pf = 0, lf = 0;
  int emits = 0;
  int seed = 32'h8479002b;
  int mreg [0:31];
  lps_if link ();
  always #20 clk_i = ~clk_i;
  lps_host lps_host_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(link.host),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));
  lps_dev #(.STEP_CYC(20)) lps_dev_inst (.clk_i(clk_i), .rst_i(rst_i),
    .bus(link.dev), .light_sample_i(light_s), .ir_sample_i(ir_s),
    .prox_sample_i(prox_s), .int_n_o(int_n_o), .emitter_on_o(emit),
    .emitter_drive_select_o(sel[7:6]), .prox_diode_select_o(sel[5:4]),
    .prox_gain_select_o(sel[3:2]), .light_gain_select_o(sel[1:0]));
  lps_link_properties lps_link_properties_inst (.clk_i(clk_i),
    .rst_i(rst_i), .scl(link.scl), .sda(link.sda),
    .scl_host_oe(link.scl_host_oe), .sda_host_oe(link.sda_host_oe),
    .sda_dev_oe(link.sda_dev_oe));
  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic single Wishbone cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // One link operation, polled until done
  task automatic op(input logic [1:0] k, input logic [7:0] c,
    input logic [7:0] d);
    wb(1'b1, 4'h0, {14'h0, k, d, c});
    rdat = 32'h1;
    while (rdat[0] !== 1'b0) wb(1'b0, 4'h4, 32'h0);
    chk("nack", 16'h0, {15'h0, rdat[1]});
    if (k == 2'h1) begin
      wb(1'b0, 4'h8, 32'h0);
      word = rdat[15:0];
    end
  endtask
  // Register write and word read against the model
  task automatic wr(input logic [4:0] r, input logic [7:0] d);
    op(2'h0, {3'h4, r}, d);
    mreg[r] = d;
  endtask
  task automatic rd(input logic [4:0] r);
    op(2'h1, {3'h5, r}, 8'h0);
    chk("word", {8'(mreg[r + 5'h1]), 8'(mreg[r])}, word);
  endtask
  task automatic int_ok();
    logic e;
    e = !(pf && mreg[0][5] || lf && mreg[0][4]);
    chk("int_n", {15'h0, e}, {15'h0, int_n_o});
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (emit === 1'b1) emits++;
    if (cycles == LIMIT) begin
      miscompares++;
      stop_test();
    end
  end
  // Main sequence
  initial begin
    for (int i = 0; i < 32; i++) mreg[i] = 0;
    mreg[2] = 255;
    mreg[3] = 255;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    int_ok();
    chk("emitter", 16'h0, 16'(emits));
    rd(5'h02);
    wr(5'h01, 8'hFF);
    wr(5'h0A, 8'h80 | 8'($random(seed)));
    rd(5'h0A);
    wr(5'h0F, 8'h20);
    chk("select", 16'(mreg[15]), {8'h0, sel});
    @(posedge clk_i);
    prox_s <= 16'h0100 | 16'($random(seed));
    ir_s <= 16'($random(seed));
    wr(5'h00, 8'h37);
    repeat (1500) @(posedge clk_i);
    pf = 1;
    int_ok();
    chk("emitter", 16'h1, {15'h0, emits > 0});
    mreg[24] = prox_s;
    mreg[25] = prox_s >> 8;
    rd(5'h18);
    // Raise, hold while inside, then clear each kind
    for (int k = 0; k < 2; k++) begin
      if (k == 1) begin
        @(posedge clk_i);
        light_s <= 16'h1 | 16'($random(seed));
        repeat (1500) @(posedge clk_i);
        lf = 1;
        int_ok();
      end
      @(posedge clk_i);
      prox_s <= 16'h0;
      light_s <= 16'h0;
      repeat (1500) @(posedge clk_i);
      int_ok();
      op(2'h2, (k == 1) ? 8'hE6 : 8'hE5, 8'h0);
      if (k == 0) pf = 0;
      else lf = 0;
      repeat (20) @(posedge clk_i);
      int_ok();
    end
    // Proximity event with its interrupt gated off
    wr(5'h00, 8'h1F);
    @(posedge clk_i);
    prox_s <= 16'hFFFF;
    repeat (1500) @(posedge clk_i);
    pf = 1;
    int_ok();
    stop_test();
  end
endmodule
